// [amp_ctrl_pkg.sv]
// shared constants and types for the amplifier two-wire control port
package amp_ctrl_pkg;

   // ----------------------------------------------------------------
   // device address and register map
   // ----------------------------------------------------------------
   localparam logic [5:0] DEV_ADDR_BASE = 6'h36;
   localparam logic [7:0] ANALOG_CFG_IDX = 8'h06;
   localparam logic [7:0] ANALOG_CFG_RST = 8'h51;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam int PBM_BIT = 7;
   localparam int CHSEL_BIT = 1;
   localparam int GAIN_MSB = 3;
   localparam int GAIN_LSB = 2;

   // ----------------------------------------------------------------
   // pin vector positions and strap settle time
   // ----------------------------------------------------------------
   localparam int PIN_SDA = 0;
   localparam int PIN_SCL = 1;
   localparam int PIN_STRAP = 2;
   localparam int PIN_G0 = 3;
   localparam int PIN_G1 = 4;
   localparam logic [2:0] STRAP_SETTLE = 3'h4;
   localparam logic [4:0] PIN_IDLE = 5'h03;

   // ----------------------------------------------------------------
   // bus clock timing of the master
   // ----------------------------------------------------------------
   localparam int CORE_CLK_NS = 10;
   localparam int BUS_CLK_NS = 2500;
   localparam int QUARTER_CYC = BUS_CLK_NS / (4 * CORE_CLK_NS);
   localparam logic [7:0] QUARTER_CNT = 8'(QUARTER_CYC - 1);

   // ----------------------------------------------------------------
   // master command registers
   // ----------------------------------------------------------------
   localparam logic [3:0] HREG_INDEX = 4'h0;
   localparam logic [3:0] HREG_WDATA = 4'h1;
   localparam logic [3:0] HREG_CTRL = 4'h2;
   localparam logic [3:0] HREG_STATUS = 4'h3;
   localparam logic [3:0] HREG_RDATA = 4'h4;
   localparam int CTRL_GO_WR = 0;
   localparam int CTRL_GO_RD = 1;
   localparam int CTRL_ADDR_SEL = 2;
   localparam logic [7:0] HREG_RST = 8'h00;

   typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK, D_SKIP} dev_fsm_type;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} host_fsm_type;

endpackage : amp_ctrl_pkg

// [amp_link_if.sv]
// two-wire link between the master and the amplifier control port
`timescale 1ns/1ns
`default_nettype none
interface amp_link_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // wired-and with pull-ups
   assign scl = host_scl_oe_n | host_scl_o;
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                 output host_sda_o, output host_sda_oe_n);
endinterface : amp_link_if
`default_nettype wire

// [amp_ctrl_port.sv]
// slave control port of the amplifier with its analog configuration register
// What this block does
// - analog reg bit 7 selects parallel bridge
// - bit 1 picks parallel-mode input channel
// - host sets boost before unmute, leaves it; this port keeps no boost register
// - analog gain from bits 3:2
// - address 110110 plus strap bit, latched once
// - strap low 1101100, strap high 1101101
// - first byte: address then direction bit
// - works at 100 and 400 kHz
// - slave only, never drives clock
// - bytes of eight bits, MSB first
// - receiver acknowledges in ninth clock
// - start and stop from SDA while SCL high
// - data changes only while SCL low
// - ack holds SDA low whole period
// - unlimited bytes until stop
// - write: address, index, data, each acked
// - both gain straps high enable the port
// - read: index write, restart, data, nack
`timescale 1ns/1ns
`default_nettype none
module amp_ctrl_port
   import amp_ctrl_pkg::*;
(
   // clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   // straps
   input wire logic SLEEP_ADDR_STRAP_PIN,
   input wire logic [1:0] GAIN_STRAP,
   // link
   amp_link_if.dev LINK,
   // analog configuration outputs and the software control mode from the gain straps
   output logic PARALLEL_BRIDGE_MODE,
   output logic PARALLEL_CHANNEL_SEL,
   output logic [1:0] ANALOG_PATH_GAIN,
   output logic SW_CONTROL_MODE
);

   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] flt;
      logic [2:0] settle;
      logic latched;
      logic addr_lsb;
      logic sw_mode;
      dev_fsm_type st;
      logic [3:0] cnt;
      logic [1:0] phase;
      logic rw;
      logic nack;
      logic [7:0] shift;
      logic [7:0] index;
      logic [7:0] analog;
      logic pull;
   } dev_regs_type;

   dev_regs_type q;
   dev_regs_type d;

   function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic [7:0] an);
      read_reg = (idx == ANALOG_CFG_IDX) ? an : UNMAPPED_READ;
   endfunction : read_reg

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic rise;
      logic fall;
      logic start_c;
      logic stop_c;
      logic [7:0] rd_val;
      rise = 1'b0;
      fall = 1'b0;
      start_c = 1'b0;
      stop_c = 1'b0;
      rd_val = 8'h00;
      d = q;

      // three stages; a level counts once stages two and three agree
      d.s1 = {GAIN_STRAP, SLEEP_ADDR_STRAP_PIN, LINK.scl, LINK.sda};
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.flt = (q.s2 & q.s3) | (q.flt & (q.s2 | q.s3));

      // filter latency is a few core cycles, far under a 400 kHz quarter
      rise = ~q.flt[PIN_SCL] & d.flt[PIN_SCL];
      fall = q.flt[PIN_SCL] & ~d.flt[PIN_SCL];
      start_c = q.flt[PIN_SCL] & d.flt[PIN_SCL] & q.flt[PIN_SDA] & ~d.flt[PIN_SDA];
      stop_c = q.flt[PIN_SCL] & d.flt[PIN_SCL] & ~q.flt[PIN_SDA] & d.flt[PIN_SDA];

      // strap taken once after the synchroniser has filled
      if (!q.latched) begin
         if (q.settle == STRAP_SETTLE) begin
            d.addr_lsb = q.flt[PIN_STRAP];
            d.latched = 1'b1;
         end else begin
            d.settle = q.settle + 3'h1;
         end
      end
      d.sw_mode = q.latched & q.flt[PIN_G0] & q.flt[PIN_G1];

      if (!q.sw_mode) begin
         d.st = D_IDLE;
         d.pull = 1'b0;
      end else if (start_c) begin
         // also a repeated start in the middle of a transfer
         d.st = D_RECV;
         d.cnt = 4'h0;
         d.phase = 2'h0;
         d.pull = 1'b0;
      end else if (stop_c) begin
         d.st = D_IDLE;
         d.pull = 1'b0;
      end else begin
         case (q.st)
            D_RECV: begin
               if (rise && q.cnt < 4'h8) begin
                  d.shift = {q.shift[6:0], q.flt[PIN_SDA]};
                  d.cnt = q.cnt + 4'h1;
               end else if (fall && q.cnt == 4'h8) begin
                  case (q.phase)
                     2'h0: begin
                        if (q.shift[7:1] == {DEV_ADDR_BASE, q.addr_lsb}) begin
                           d.rw = q.shift[0];
                           d.pull = 1'b1;
                           d.st = D_ACK;
                        end else begin
                           d.st = D_SKIP;
                        end
                     end
                     2'h1: begin
                        d.index = q.shift;
                        d.pull = 1'b1;
                        d.st = D_ACK;
                     end
                     default: begin
                        if (q.index == ANALOG_CFG_IDX) begin
                           d.analog = q.shift;
                        end
                        d.index = q.index + 8'h01;
                        d.pull = 1'b1;
                        d.st = D_ACK;
                     end
                  endcase
               end
            end
            D_ACK: begin
               // held low from one falling edge to the next
               if (fall) begin
                  d.cnt = 4'h0;
                  if (q.phase == 2'h0 && q.rw) begin
                     rd_val = read_reg(q.index, q.analog);
                     d.shift = rd_val;
                     d.pull = ~rd_val[7];
                     d.st = D_SEND;
                  end else begin
                     d.pull = 1'b0;
                     d.phase = (q.phase == 2'h2) ? 2'h2 : q.phase + 2'h1;
                     d.st = D_RECV;
                  end
               end
            end
            D_SEND: begin
               if (fall) begin
                  if (q.cnt == 4'h7) begin
                     d.pull = 1'b0;
                     d.index = q.index + 8'h01;
                     d.st = D_MACK;
                  end else begin
                     d.cnt = q.cnt + 4'h1;
                     d.shift = {q.shift[6:0], 1'b0};
                     d.pull = ~q.shift[6];
                  end
               end
            end
            D_MACK: begin
               if (rise) begin
                  d.nack = q.flt[PIN_SDA];
               end else if (fall) begin
                  if (q.nack) begin
                     d.st = D_SKIP;
                  end else begin
                     rd_val = read_reg(q.index, q.analog);
                     d.shift = rd_val;
                     d.pull = ~rd_val[7];
                     d.cnt = 4'h0;
                     d.st = D_SEND;
                  end
               end
            end
            D_SKIP: begin
               d.pull = 1'b0;
            end
            default: begin
               d.pull = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         q <= '0;
         // bus lines start at their idle high, so no false edge leaves reset
         q.s1 <= PIN_IDLE;
         q.s2 <= PIN_IDLE;
         q.s3 <= PIN_IDLE;
         q.flt <= PIN_IDLE;
         q.analog <= ANALOG_CFG_RST;
      end else if (CE) begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs; only the data line is ever pulled, the clock never
   // ----------------------------------------------------------------
   assign LINK.dev_sda_o = 1'b0;
   assign LINK.dev_sda_oe_n = ~q.pull;
   assign PARALLEL_BRIDGE_MODE = q.analog[PBM_BIT];
   assign PARALLEL_CHANNEL_SEL = q.analog[CHSEL_BIT];
   assign ANALOG_PATH_GAIN = q.analog[GAIN_MSB:GAIN_LSB];
   assign SW_CONTROL_MODE = q.sw_mode;

endmodule : amp_ctrl_port
`default_nettype wire

// [amp_ctrl_master.sv]
// two-wire master that writes and reads one register of the amplifier
`timescale 1ns/1ns
`default_nettype none
module amp_ctrl_master
   import amp_ctrl_pkg::*;
(
   // clock, reset, enable
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic CE,
   // command registers
   input wire logic [3:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   output logic BUSY,
   // link
   amp_link_if.host LINK
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic flt;
      host_fsm_type st;
      logic [7:0] div;
      logic [1:0] ph;
      logic [3:0] bit_cnt;
      logic [2:0] step;
      logic rd;
      logic ackb;
      logic nack_err;
      logic addr_sel;
      logic [7:0] index;
      logic [7:0] wdata;
      logic [7:0] rdata;
      logic [7:0] shift;
      logic [7:0] rdo;
      logic scl_low;
      logic sda_low;
      logic busy;
   } host_regs_type;

   host_regs_type q;
   host_regs_type d;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic tick;
      logic tx;
      tick = 1'b0;
      tx = (q.step != 3'h4);
      d = q;

      d.s1 = LINK.sda;
      d.s2 = q.s1;
      d.s3 = q.s2;
      if (q.s2 == q.s3) begin
         d.flt = q.s3;
      end

      // command port; start requests while busy are dropped, index and data writes are taken
      if (REG_WR) begin
         case (REG_ADDR)
            HREG_INDEX: d.index = REG_WDATA;
            HREG_WDATA: d.wdata = REG_WDATA;
            HREG_CTRL: begin
               if (q.st == H_IDLE) begin
                  d.addr_sel = REG_WDATA[CTRL_ADDR_SEL];
                  if (REG_WDATA[CTRL_GO_WR] || REG_WDATA[CTRL_GO_RD]) begin
                     d.rd = REG_WDATA[CTRL_GO_RD] & ~REG_WDATA[CTRL_GO_WR];
                     d.st = H_START;
                     d.step = 3'h0;
                     d.ph = 2'h0;
                     d.div = 8'h00;
                     d.nack_err = 1'b0;
                  end
               end
            end
            default: d.index = q.index;
         endcase
      end
      d.rdo = 8'h00;
      if (REG_RD) begin
         case (REG_ADDR)
            HREG_INDEX: d.rdo = q.index;
            HREG_WDATA: d.rdo = q.wdata;
            HREG_CTRL: d.rdo = {5'h00, q.addr_sel, 2'h0};
            HREG_STATUS: d.rdo = {6'h00, q.nack_err, q.busy};
            HREG_RDATA: d.rdo = q.rdata;
            default: d.rdo = 8'h00;
         endcase
      end

      // quarter-period divider makes the bus clock
      if (q.st != H_IDLE) begin
         if (q.div == QUARTER_CNT) begin
            d.div = 8'h00;
            tick = 1'b1;
         end else begin
            d.div = q.div + 8'h01;
         end
      end

      if (tick) begin
         d.ph = q.ph + 2'h1;
         case (q.st)
            H_START: begin
               case (q.ph)
                  2'h0: d.sda_low = 1'b0;
                  2'h1: d.scl_low = 1'b0;
                  2'h2: d.sda_low = 1'b1;
                  default: begin
                     d.scl_low = 1'b1;
                     d.st = H_BYTE;
                     d.bit_cnt = 4'h0;
                     d.shift = {DEV_ADDR_BASE, q.addr_sel, q.step != 3'h0};
                  end
               endcase
            end
            H_BYTE: begin
               case (q.ph)
                  2'h0: d.sda_low = (q.bit_cnt < 4'h8) & tx & ~q.shift[7];
                  2'h1: d.scl_low = 1'b0;
                  2'h2: begin
                     if (q.bit_cnt < 4'h8) begin
                        d.shift = {q.shift[6:0], q.flt};
                     end else begin
                        d.ackb = q.flt;
                     end
                  end
                  default: begin
                     d.scl_low = 1'b1;
                     d.bit_cnt = q.bit_cnt + 4'h1;
                     if (q.bit_cnt == 4'h8) begin
                        d.bit_cnt = 4'h0;
                        if (tx && q.ackb) begin
                           d.nack_err = 1'b1;
                           d.st = H_STOP;
                        end else begin
                           case (q.step)
                              3'h0: begin
                                 d.step = 3'h1;
                                 d.shift = q.index;
                              end
                              3'h1: begin
                                 if (q.rd) begin
                                    d.step = 3'h3;
                                    d.st = H_START;
                                 end else begin
                                    d.step = 3'h2;
                                    d.shift = q.wdata;
                                 end
                              end
                              3'h3: begin
                                 d.step = 3'h4;
                                 d.shift = 8'hFF;
                              end
                              3'h4: begin
                                 d.rdata = q.shift;
                                 d.st = H_STOP;
                              end
                              default: d.st = H_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (q.ph)
                  2'h0: d.sda_low = 1'b1;
                  2'h1: d.scl_low = 1'b0;
                  2'h2: d.sda_low = 1'b0;
                  default: d.st = H_IDLE;
               endcase
            end
            default: d.st = H_IDLE;
         endcase
      end
      d.busy = (d.st != H_IDLE);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         q <= '0;
         q.index <= HREG_RST;
      end else if (CE) begin
         q <= d;
      end
   end

   assign REG_RDATA = q.rdo;
   assign BUSY = q.busy;
   assign LINK.host_scl_o = 1'b0;
   assign LINK.host_scl_oe_n = ~q.scl_low;
   assign LINK.host_sda_o = 1'b0;
   assign LINK.host_sda_oe_n = ~q.sda_low;

endmodule : amp_ctrl_master
`default_nettype wire

// [amp_ctrl_port_end.sv]
// intentionally left out

// [amp_i2c_control_port_chk.sv]
// link checker for the amplifier control port and its master
`timescale 1ns/1ns
`default_nettype none
module amp_i2c_control_port_chk
   import amp_ctrl_pkg::*;
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST,
   // device straps
   input wire logic SLEEP_ADDR_STRAP_PIN,
   input wire logic [1:0] GAIN_STRAP,
   // link
   input wire logic scl,
   input wire logic sda,
   input wire logic host_scl_oe_n,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_oe_n
);
   typedef struct packed {
      logic scl_p;
      logic sda_p;
      logic first;
      logic foreign;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] hi;
   } mon_type;
   mon_type mon_q;
   mon_type mon_d;
   logic rise;
   logic start;
   logic stop;
   logic miss;
   assign rise = scl & ~mon_q.scl_p;
   assign start = scl & mon_q.scl_p & mon_q.sda_p & ~sda;
   assign stop = scl & mon_q.scl_p & ~mon_q.sda_p & sda;
   assign miss = (mon_q.sh[7:1] != {DEV_ADDR_BASE, SLEEP_ADDR_STRAP_PIN}) | ~&GAIN_STRAP;

   // ----
   // bit counter and address capture from the wire
   // ----
   always_comb begin
      mon_d = mon_q;
      mon_d.scl_p = scl;
      mon_d.sda_p = sda;
      mon_d.hi = !scl ? 8'h00 : (mon_q.hi == 8'hFF) ? 8'hFF : mon_q.hi + 8'h01;
      if (start) begin
         mon_d.cnt = 4'h0;
         mon_d.first = 1'b1;
         mon_d.foreign = 1'b0;
      end else if (rise) begin
         mon_d.cnt = (mon_q.cnt == 4'h8) ? 4'h0 : mon_q.cnt + 4'h1;
         if (mon_q.cnt < 4'h8) begin
            mon_d.sh = {mon_q.sh[6:0], sda};
         end else begin
            mon_d.first = 1'b0;
            mon_d.foreign = mon_q.foreign | (mon_q.first & miss);
         end
      end
   end

   // idle-high reset values keep the first cycle from faking edges
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         mon_q <= '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 8'h00, 8'hFF};
      end else begin
         mon_q <= mon_d;
      end
   end

   // ----
   // properties
   // ----
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   chk_scl_host_only: assert property (!scl |-> !host_scl_oe_n)
      else $error("clock line low without the master pulling it");
   chk_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
      else $error("device changed data while clock high");
   chk_ack_hold: assert property (rise && !dev_sda_oe_n |-> !dev_sda_oe_n [*8])
      else $error("device let go of data during clock high");
   chk_start_free: assert property (start |-> dev_sda_oe_n)
      else $error("device driving data at a start");
   chk_stop_free: assert property (stop |=> dev_sda_oe_n [*8])
      else $error("device pulled data right after a stop");
   chk_addr_ack: assert property (rise && mon_q.cnt == 4'h8 && mon_q.first
      |-> dev_sda_oe_n == miss)
      else $error("address acknowledge wrong");
   chk_foreign_quiet: assert property (mon_q.foreign |-> dev_sda_oe_n)
      else $error("device drove data after a foreign address");
   chk_scl_high_time: assert property (!scl && mon_q.scl_p |-> mon_q.hi >= 8'(QUARTER_CYC))
      else $error("clock high time too short");
endmodule : amp_i2c_control_port_chk
`default_nettype wire

// [amp_i2c_control_port_tb_top.sv]
// testbench joining the control port and its master over the link
`timescale 1ns/1ns
`default_nettype none
module amp_i2c_control_port_tb_top;
   import amp_ctrl_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic [1:0] gain_strap = 2'b11;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic rd_q = 1'b0;
   logic [7:0] reg_rdata;
   logic busy;
   logic pbm;
   logic chsel;
   logic sw_mode;
   logic [1:0] gain;
   logic [7:0] exp_q[$];
   int n_errors = 0;
   int tests_run = 0;

   amp_link_if link ();
   amp_ctrl_port u_amp_ctrl_port (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1),
      .SLEEP_ADDR_STRAP_PIN(strap), .GAIN_STRAP(gain_strap), .LINK(link.dev),
      .PARALLEL_BRIDGE_MODE(pbm), .PARALLEL_CHANNEL_SEL(chsel),
      .ANALOG_PATH_GAIN(gain), .SW_CONTROL_MODE(sw_mode));
   amp_ctrl_master u_amp_ctrl_master (.CORE_CLK(core_clk), .RST(rst), .CE(1'b1),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_RDATA(reg_rdata), .BUSY(busy), .LINK(link.host));
   amp_i2c_control_port_chk u_amp_i2c_control_port_chk (.CORE_CLK(core_clk), .RST(rst),
      .SLEEP_ADDR_STRAP_PIN(strap), .GAIN_STRAP(gain_strap), .scl(link.scl),
      .sda(link.sda), .host_scl_oe_n(link.host_scl_oe_n),
      .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_oe_n(link.dev_sda_oe_n));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   // ----
   // checking and closing
   // ----
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      tests_run++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, seen);
         n_errors++;
      end
   endtask : check

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) begin
      if (rd_q) begin
         check(reg_rdata, exp_q.pop_front(), "register read");
      end
      rd_q <= reg_rd;
   end

   // ----
   // register port and link transfers
   // ----
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask : rd

   task automatic go(input logic [7:0] ctrl, input logic nack);
      int i;
      wr(HREG_CTRL, ctrl);
      check({7'h00, busy}, 8'h01, "busy");
      @(posedge core_clk);
      for (i = 0; i < 20000 && busy !== 1'b0; i++) begin
         @(posedge core_clk);
      end
      if (i == 20000) begin
         n_errors++;
         report_and_stop();
      end
      rd(HREG_STATUS, {6'h00, nack, 1'b0});
   endtask : go

   task automatic dev_wr(input logic [7:0] idx, input logic [7:0] d, input logic sel,
                         input logic nack);
      wr(HREG_INDEX, idx);
      wr(HREG_WDATA, d);
      go({5'h00, sel, 2'h1}, nack);
      rd(HREG_WDATA, d);
      rd(HREG_CTRL, {5'h00, sel, 2'h0});
   endtask : dev_wr

   task automatic dev_rd(input logic [7:0] idx, input logic sel, input logic [7:0] e);
      wr(HREG_INDEX, idx);
      rd(HREG_INDEX, idx);
      go({5'h00, sel, 2'h2}, 1'b0);
      rd(HREG_RDATA, e);
   endtask : dev_rd

   task automatic outs(input logic [7:0] r);
      check({7'h00, pbm}, {7'h00, r[PBM_BIT]}, "bridge mode");
      check({7'h00, chsel}, {7'h00, r[CHSEL_BIT]}, "channel select");
      check({6'h00, gain}, {6'h00, r[GAIN_MSB:GAIN_LSB]}, "analog gain");
   endtask : outs

   // strap only moves while reset is held, as at power-up
   task automatic do_reset(input logic s);
      rst <= 1'b1;
      strap <= s;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      repeat (30) @(posedge core_clk);
   endtask : do_reset

   // ----
   // main sequence
   // ----
   initial begin
      logic [7:0] cfg;
      int g;
      void'($urandom(32'h54EA5DE4));
      do_reset(1'b0);
      check({7'h00, sw_mode}, 8'h01, "software mode");
      outs(ANALOG_CFG_RST);
      rd(4'hF, 8'h00);
      dev_rd(ANALOG_CFG_IDX, 1'b0, ANALOG_CFG_RST);
      // boost set once before any gain or mode change; not kept by this port
      dev_wr(8'h02, 8'($urandom()), 1'b0, 1'b0);
      dev_rd(8'h02, 1'b0, UNMAPPED_READ);
      outs(ANALOG_CFG_RST);
      cfg = ANALOG_CFG_RST;
      for (g = 0; g < 4; g++) begin
         cfg = 8'($urandom());
         cfg[GAIN_MSB:GAIN_LSB] = 2'(g);
         dev_wr(ANALOG_CFG_IDX, cfg, 1'b0, 1'b0);
         outs(cfg);
      end
      dev_rd(ANALOG_CFG_IDX, 1'b0, cfg);
      dev_wr(ANALOG_CFG_IDX, ~cfg, 1'b1, 1'b1);
      outs(cfg);
      do_reset(1'b1);
      outs(ANALOG_CFG_RST);
      dev_wr(ANALOG_CFG_IDX, ~cfg, 1'b0, 1'b1);
      dev_wr(ANALOG_CFG_IDX, cfg, 1'b1, 1'b0);
      outs(cfg);
      gain_strap <= 2'b01;
      repeat (20) @(posedge core_clk);
      check({7'h00, sw_mode}, 8'h00, "software mode");
      dev_wr(ANALOG_CFG_IDX, ~cfg, 1'b1, 1'b1);
      outs(cfg);
      repeat (4) @(posedge core_clk);
      report_and_stop();
   end
endmodule : amp_i2c_control_port_tb_top
`default_nettype wire
